// file: hdl/scp_clock_prescaler.sv
`timescale 1ns/1ps
module scp_clock_prescaler
  import scp_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  input  wire logic                fuse_cpu_undivided_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [ADDR_W-1:0]   paddr_in,
  input  wire logic [DATA_W-1:0]   pwdata_in,
  input  wire logic [3:0]          pstrb_in,
  output logic                     pready_out,
  output logic [DATA_W-1:0]        prdata_out,
  output logic                     pslverr_out,
  output logic                     sys_tick_out,
  output logic                     cpu_tick_out,
  output logic                     sys_clk_out,
  output logic                     tps_tick_out,
  output logic [N_PERIPH-1:0]      periph_tick_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0]        fuse_sync;
    logic [1:0]        fuse_wait;
    logic [7:0]        pcs0;
    logic [7:0]        reload;
    logic              pcs1;
    logic [3:0]        timer_prescale_field;
    logic              fast;
    logic [1:0]        ca_src;
    logic              xdiv;
    logic [7:0]        pre_cnt;
    logic [7:0]        reload_act;
    logic              sys_clk;
    logic [3:0]        tps_cnt;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } scp_state_t;

  localparam scp_state_t STATE_RST = '{
    fuse_sync:  2'h0,
    fuse_wait:  FUSE_WAIT,
    pcs0:       PCS0_RST,
    reload:     RELOAD_RST,
    pcs1:       1'b0,
    timer_prescale_field:        TPS_RST,
    fast:       1'b0,
    ca_src:     SRC_TPS,
    xdiv:       1'b0,
    pre_cnt:    8'h00,
    reload_act: RELOAD_RST,
    sys_clk:    1'b0,
    tps_cnt:    TPS_RST,
    prdata:     32'h0000_0000,
    pslverr:    1'b0
  };

  scp_state_t               st_ff;
  scp_state_t               nxt_st;

  logic                     xtick;
  logic                     overflow;
  logic                     bypass;
  logic                     sys_tick;
  logic                     tps_tick;
  logic                     setup_ph;
  logic                     access_ph;
  logic                     wr_en;
  logic [IDX_W-1:0]         idx;
  logic                     hit;
  logic [DATA_W-1:0]        rd_mux;
  logic [N_PERIPH-1:0]      sel_vec;
  logic [N_PERIPH-1:0]      tps_vec;
  logic [N_PERIPH-1:0]      tick_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  always_comb begin
    setup_ph  = psel_in & ~penable_in;
    access_ph = psel_in & penable_in;
    wr_en     = access_ph & pwrite_in & pstrb_in[0];
    idx       = paddr_in[ADDR_W-1:2];
    hit       = 1'b1;
    rd_mux    = 32'h0000_0000;
    unique case (idx)
      IDX_PCS0: begin
        rd_mux[7:0] = st_ff.pcs0;
      end
      IDX_RELOAD: begin
        rd_mux[7:0] = st_ff.reload;
      end
      IDX_PCS1: begin
        rd_mux[0] = st_ff.pcs1;
      end
      IDX_TPC: begin
        rd_mux[TPS_MSB:TPS_LSB] = st_ff.timer_prescale_field;
      end
      IDX_MODE: begin
        rd_mux[MODE_FAST_BIT]              = st_ff.fast;
        rd_mux[MODE_SRC_MSB:MODE_SRC_LSB]  = st_ff.ca_src;
      end
      IDX_STATUS: begin
        // Live prescaler state, read only
        rd_mux[0]     = st_ff.sys_clk;
        rd_mux[1]     = bypass;
        rd_mux[7:4]   = st_ff.tps_cnt;
        rd_mux[15:8]  = st_ff.pre_cnt;
        rd_mux[23:16] = st_ff.reload_act;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock chain: oscillator, X2 stage, system prescaler, timer prescaler

  always_comb begin
    // Divide-by-two stage keeps a 50 percent duty cycle when not undivided
    xtick    = st_ff.pcs0[PCS0_UNDIV_BIT] ? 1'b1 : st_ff.xdiv;
    overflow = xtick & (st_ff.pre_cnt == PRE_TOP);
    bypass   = (st_ff.reload_act == RELOAD_OFF);
    if (bypass) begin
      sys_tick = xtick;
    end else begin
      // One system period spans two overflows, ratio even by construction
      sys_tick = overflow & ~st_ff.sys_clk;
    end
    tps_tick = sys_tick & (st_ff.tps_cnt == TPS_ZERO);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;

    // Fuse pin passes two flops before use
    nxt_st.fuse_sync = {st_ff.fuse_sync[0], fuse_cpu_undivided_in};
    if (st_ff.fuse_wait != FUSE_DONE) begin
      nxt_st.fuse_wait = st_ff.fuse_wait - FUSE_STEP;
    end
    if (st_ff.fuse_wait == FUSE_LOAD) begin
      nxt_st.pcs0[PCS0_UNDIV_BIT] = st_ff.fuse_sync[1];
    end

    nxt_st.xdiv = ~st_ff.xdiv;

    // Counter keeps running in bypass so a new reload is picked up promptly
    if (xtick) begin
      if (overflow) begin
        // Loaded one past the reload so each overflow spans 255 minus reload ticks
        nxt_st.pre_cnt    = st_ff.reload + PRE_ONE;
        nxt_st.reload_act = st_ff.reload;
        nxt_st.sys_clk    = ~st_ff.sys_clk;
      end else begin
        nxt_st.pre_cnt = st_ff.pre_cnt + PRE_ONE;
      end
    end
    // Worst case wait is 256 stage ticks, 512 oscillator periods
    if (bypass) begin
      nxt_st.sys_clk = 1'b0;
    end

    if (sys_tick) begin
      if (st_ff.tps_cnt == TPS_ZERO) begin
        nxt_st.tps_cnt = st_ff.timer_prescale_field;
      end else begin
        nxt_st.tps_cnt = st_ff.tps_cnt - TPS_ONE;
      end
    end

    // Read data and error captured in setup, shown in access
    if (setup_ph) begin
      nxt_st.prdata  = rd_mux;
      nxt_st.pslverr = ~hit;
    end

    // Software write follows the fuse load so it wins in a shared cycle
    if (wr_en) begin
      unique case (idx)
        IDX_PCS0: begin
          nxt_st.pcs0 = pwdata_in[7:0];
        end
        IDX_RELOAD: begin
          nxt_st.reload = pwdata_in[7:0];
        end
        IDX_PCS1: begin
          nxt_st.pcs1 = pwdata_in[0];
        end
        IDX_TPC: begin
          nxt_st.timer_prescale_field = pwdata_in[TPS_MSB:TPS_LSB];
        end
        IDX_MODE: begin
          nxt_st.fast   = pwdata_in[MODE_FAST_BIT];
          nxt_st.ca_src = pwdata_in[MODE_SRC_MSB:MODE_SRC_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-peripheral selection

  always_comb begin
    sel_vec             = '0;
    sel_vec[P_TIMER0]   = st_ff.pcs0[1];
    sel_vec[P_TIMER1]   = st_ff.pcs0[2];
    sel_vec[P_TIMER2]   = st_ff.pcs0[3];
    sel_vec[P_SERIAL]   = st_ff.pcs0[4];
    sel_vec[P_CARRAY]   = st_ff.pcs0[5];
    sel_vec[P_WATCHDOG] = st_ff.pcs0[6];
    sel_vec[P_TWOWIRE]  = st_ff.pcs0[7];
    sel_vec[P_SPI]      = st_ff.pcs1;

    tps_vec             = '0;
    tps_vec[P_TIMER0]   = 1'b1;
    tps_vec[P_TIMER1]   = 1'b1;
    tps_vec[P_TIMER2]   = 1'b1;
    tps_vec[P_WATCHDOG] = 1'b1;
    // Other source codes clock from outside, the prescaled base is the fallback
    tps_vec[P_CARRAY]   = (st_ff.ca_src != SRC_CPU);
  end

  // Two-wire tick only paces the master SCL generator
  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi++) begin : g_periph
      scp_tick_if tif ();
      assign tif.sys_tick  = sys_tick;
      assign tif.tps_tick  = tps_tick;
      assign tif.fast      = st_ff.fast;
      assign tif.sel       = sel_vec[gi];
      assign tif.uses_tps  = tps_vec[gi];
      assign tick_vec[gi]  = tif.tick;
      scp_tick_sel u_sel (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .tif        (tif.sel_side)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    pready_out      = access_ph;
    prdata_out      = st_ff.prdata;
    pslverr_out     = access_ph & st_ff.pslverr;
    sys_tick_out    = sys_tick;
    cpu_tick_out    = sys_tick;
    sys_clk_out     = st_ff.sys_clk;
    tps_tick_out    = tps_tick;
    periph_tick_out = tick_vec;
  end

endmodule

// file: hdl/scp_pkg.sv
// Behaviour
// - System prescaler is an 8-bit up counter reloaded from the reload register on wrap.
// - Reload of all ones bypasses the prescaler; system rate is oscillator times 2^X2 over two.
// - Other reloads toggle system clock per overflow: osc times 2^X2 over 4(255-reload).
// - Division covers even ratios 4 to 1020 divided, 2 to 510 undivided.
// - Reload register writable any time; new value used from the next overflow.
// - New system rate is in effect within 1024 oscillator periods after a reload write.
// - The divided system clock drives CPU and all peripherals as base peripheral clock.
// - Reset loads all ones into the reload register, prescaler disabled.
// - Shared 4-bit timer prescaler counts down, reloads at zero, divides by field plus one.
// - Timer prescale field resets to five, six CPU cycles per timer count.
// - Compatibility mode applies timer prescaler to timers, watchdog and counter array (not source 01); fast mode only where selection bit set.
// - Compat: CPU over 2^sel times (field+1); fast: set gives over (field+1), clear CPU clock.
// - Compat peripherals outside timer prescaler pick CPU clock or CPU clock over two.
// - Two-wire bit picks one or two clocks compat, one or field+1 fast; SCL only.
// - Watchdog bit picks field+1 or twice that compat, one or field+1 fast.
// - Counter-array source 00: bit picks field+1 or twice compat, one or field+1 fast.
// - Counter-array source 01: bit picks one or two clocks compat, one or field+1 fast.
// - CPU clock mode bit clear halves the oscillator clock; set passes it undivided.
// - Timer 0, 1, 2 bits pick field+1 or twice compat, one or field+1 fast.
package scp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned DATA_W   = 32;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PCS0   = 10'h08F;
  localparam logic [IDX_W-1:0] IDX_RELOAD = 10'h097;
  localparam logic [IDX_W-1:0] IDX_PCS1   = 10'h0AF;
  localparam logic [IDX_W-1:0] IDX_TPC    = 10'h0C0;
  localparam logic [IDX_W-1:0] IDX_MODE   = 10'h0C1;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0C2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned PCS0_UNDIV_BIT = 0;
  localparam int unsigned TPS_LSB        = 4;
  localparam int unsigned TPS_MSB        = 7;
  localparam int unsigned MODE_FAST_BIT  = 0;
  localparam int unsigned MODE_SRC_LSB   = 1;
  localparam int unsigned MODE_SRC_MSB   = 2;

  // Peripheral order in the tick vector
  localparam int unsigned N_PERIPH   = 8;
  localparam int unsigned P_TIMER0   = 0;
  localparam int unsigned P_TIMER1   = 1;
  localparam int unsigned P_TIMER2   = 2;
  localparam int unsigned P_SERIAL   = 3;
  localparam int unsigned P_CARRAY   = 4;
  localparam int unsigned P_WATCHDOG = 5;
  localparam int unsigned P_TWOWIRE  = 6;
  localparam int unsigned P_SPI      = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic [7:0] PCS0_RST     = 8'h00;
  localparam logic [7:0] RELOAD_RST   = 8'hFF;
  localparam logic [7:0] RELOAD_OFF   = 8'hFF;
  localparam logic [7:0] PRE_ONE      = 8'h01;
  localparam logic [7:0] PRE_TOP      = 8'hFF;
  localparam logic [3:0] TPS_RST      = 4'h5;
  localparam logic [3:0] TPS_ONE      = 4'h1;
  localparam logic [3:0] TPS_ZERO     = 4'h0;
  localparam logic [1:0] SRC_TPS      = 2'h0;
  localparam logic [1:0] SRC_CPU      = 2'h1;
  localparam logic [1:0] FUSE_WAIT    = 2'h3;
  localparam logic [1:0] FUSE_LOAD    = 2'h1;
  localparam logic [1:0] FUSE_DONE    = 2'h0;
  localparam logic [1:0] FUSE_STEP    = 2'h1;
  localparam int unsigned RELOAD_LATENCY_OSC = 1024;

endpackage

// file: hdl/scp_tick_if.sv
`timescale 1ns/1ps
interface scp_tick_if;
  logic sys_tick;
  logic tps_tick;
  logic fast;
  logic sel;
  logic uses_tps;
  logic tick;

  modport ctl (output sys_tick, output tps_tick, output fast, output sel, output uses_tps, input tick);
  modport sel_side (input sys_tick, input tps_tick, input fast, input sel, input uses_tps, output tick);
endinterface

// file: hdl/scp_tick_sel.sv
`timescale 1ns/1ps
module scp_tick_sel
  import scp_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  scp_tick_if.sel_side     tif
);

  typedef struct packed {
    logic half;
  } scp_sel_state_t;

  scp_sel_state_t sel_ff;
  scp_sel_state_t nxt_sel;
  logic           base;
  logic           halve;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_sel = sel_ff;
    if (tif.fast) begin
      base = tif.sel ? tif.tps_tick : tif.sys_tick;
    end else begin
      base = tif.uses_tps ? tif.tps_tick : tif.sys_tick;
    end
    // Extra divide by two only in compatibility mode with the bit set
    halve = ~tif.fast & tif.sel;
    if (base) begin
      nxt_sel.half = ~sel_ff.half;
    end
    tif.tick = halve ? (base & sel_ff.half) : base;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sel_ff <= '0;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

endmodule

// file: verification/scp_clock_prescaler_asserts.sv
`timescale 1ns/1ps
module scp_clock_prescaler_chk
  import scp_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                rstn_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic [ADDR_W-1:0]   paddr_in,
  input  wire logic                pready_out,
  input  wire logic                pslverr_out,
  input  wire logic                sys_tick_out,
  input  wire logic                sys_clk_out,
  input  wire logic                cpu_tick_out,
  input  wire logic                tps_tick_out,
  input  wire logic [N_PERIPH-1:0] periph_tick_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [10:0] gap_ff;
  wire  logic  mapped = paddr_in[11:2] inside {IDX_PCS0, IDX_RELOAD, IDX_PCS1, IDX_TPC, IDX_MODE, IDX_STATUS};

  // Cycles since the last system tick; wraps only long after the check fires
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in || sys_tick_out) begin
      gap_ff <= 11'h000;
    end else begin
      gap_ff <= gap_ff + 11'h001;
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////////////////
  chk_ready_now: assert property (pready_out == (psel_in && penable_in))
    else $error("ready not immediate");
  chk_err_map: assert property (psel_in && penable_in |-> pslverr_out == !mapped)
    else $error("error response wrong");
  chk_cpu_same: assert property (cpu_tick_out == sys_tick_out)
    else $error("cpu tick differs");
  chk_tps_base: assert property (tps_tick_out |-> sys_tick_out)
    else $error("timer prescale tick off base");
  chk_periph_base: assert property (|periph_tick_out |-> sys_tick_out)
    else $error("peripheral tick off base");
  chk_gap_bound: assert property (gap_ff < 11'd1024)
    else $error("system tick gap too long");
  chk_clk_rise: assert property ($rose(sys_clk_out) |-> $past(sys_tick_out))
    else $error("system clock phase rose without tick");
  chk_boot_tick: assert property ($rose(rstn_in) |-> ##[1:4] sys_tick_out)
    else $error("no tick after reset");
  chk_boot_tps: assert property ($rose(rstn_in) |-> ##[1:16] tps_tick_out)
    else $error("no timer tick after reset");
endmodule

bind scp_clock_prescaler scp_clock_prescaler_chk i_chk (.clk_sys_in, .rstn_in, .psel_in, .penable_in,
  .paddr_in, .pready_out, .pslverr_out, .sys_tick_out, .sys_clk_out, .cpu_tick_out, .tps_tick_out,
  .periph_tick_out);

// file: verification/scp_tick_sink.sv
`timescale 1ns/1ps
module scp_tick_sink (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        tick_in,
  output logic [31:0]      period_out,
  output logic [31:0]      seen_out
);
  logic [31:0] cnt_ff;

  // Consumer side: only pulse spacing matters; the first interval is partial
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cnt_ff <= 32'h00000001;
      period_out <= 32'h00000000;
      seen_out <= 32'h00000000;
    end else if (tick_in) begin
      period_out <= cnt_ff;
      seen_out <= seen_out + 32'h00000001;
      cnt_ff <= 32'h00000001;
    end else begin
      cnt_ff <= cnt_ff + 32'h00000001;
    end
  end
endmodule

// file: verification/scp_clock_prescaler_test.sv
`timescale 1ns/1ps
module scp_clock_prescaler_test;
  import scp_pkg::*;
  logic        clk_sys_in, rstn_in, fuse_cpu_undivided_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdata, period, seen, v;
  logic [3:0]  pstrb_in;
  logic        pready_out, pslverr_out, sys_tick_out, cpu_tick_out, sys_clk_out, tps_tick_out, rerr, msys;
  logic [7:0]  periph_tick_out, r;
  int          fails, n_checks, seed, cyc, pk, p, t, sp;
  wire logic   mtick = msys ? sys_tick_out : periph_tick_out[pk[2:0]];

  scp_clock_prescaler i_scp_clock_prescaler (.clk_sys_in, .rstn_in, .fuse_cpu_undivided_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .pready_out, .prdata_out, .pslverr_out,
    .sys_tick_out, .cpu_tick_out, .sys_clk_out, .tps_tick_out, .periph_tick_out);
  scp_tick_sink i_scp_tick_sink (.clk_sys_in, .rstn_in, .tick_in(mtick), .period_out(period), .seen_out(seen));

  ////////////////////////////////////////////////////////////////////////////
  always #5 clk_sys_in = ~clk_sys_in;

  // Worst case run is near 42000 cycles
  always @(posedge clk_sys_in) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      fails = fails + 1;
      close_out;
    end
  end

  task close_out;
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= {ix, 2'b00};
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) @(posedge clk_sys_in);
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Second interval after switching is the first whole one
  task meas(input logic s, input int k, output int q);
    int n;
    // Switch and sample away from the edge so no tick is lost or counted twice
    @(negedge clk_sys_in);
    msys = s;
    pk = k;
    n = seen;
    while (seen < n + 2) @(negedge clk_sys_in);
    q = period;
  endtask

  function int sexp(input logic x2, input logic [7:0] rl);
    int st;
    st = x2 ? 1 : 2;
    return (rl == 8'hFF) ? st : st * 2 * (255 - rl);
  endfunction

  function int pexp(input int s, input logic fm, input logic sel, input logic ut, input int tf);
    int tp;
    tp = s * (tf + 1);
    if (fm) return sel ? tp : s;
    return (ut ? tp : s) * (sel ? 2 : 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 0; rstn_in = 0; fuse_cpu_undivided_in = 1; psel_in = 0; penable_in = 0; pwrite_in = 0;
    paddr_in = 12'h000; pwdata_in = 32'h0; pstrb_in = 4'hF; msys = 1; pk = 0;
    fails = 0; n_checks = 0; cyc = 0; seed = 32'h055279e8;
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    apb(0, IDX_RELOAD, 0); chk(rdata, 32'h000000FF);
    apb(0, IDX_TPC, 0); chk(rdata, 32'h00000050);
    apb(0, IDX_PCS0, 0); chk(rdata, 32'h00000001);
    apb(0, 10'h001, 0); chk({rdata[30:0], rerr}, 32'h00000001);
    meas(1, 0, p); chk(p, 1);
    // Slowest and fastest ratios in both modes
    for (int i = 0; i < 4; i++) begin
      r = i[0] ? 8'hFE : 8'h00;
      apb(1, IDX_PCS0, {31'h0, i[1]});
      apb(1, IDX_RELOAD, {24'h0, r});
      apb(0, IDX_RELOAD, 0); chk(rdata, {24'h0, r});
      repeat (1024) @(posedge clk_sys_in);
      meas(1, 0, p); chk(p, sexp(i[1], r));
    end
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      r = 8'hF8 + v[14:12];
      t = v[19:16];
      apb(1, IDX_PCS0, {24'h0, v[7:0]});
      apb(1, IDX_PCS1, {31'h0, v[8]});
      apb(1, IDX_TPC, {24'h0, v[19:16], 4'h0});
      apb(1, IDX_MODE, {29'h0, v[11], v[10], v[9]});
      apb(1, IDX_RELOAD, {24'h0, r});
      repeat (1024) @(posedge clk_sys_in);
      sp = sexp(v[0], r);
      meas(1, 0, p); chk(p, sp);
      meas(0, i % 8, p);
      chk(p, pexp(sp, v[9], (i % 8 == 7) ? v[8] : v[i % 8 + 1],
        (i % 8) inside {0, 1, 2, 5} || (i % 8 == 4 && (v[11] || !v[10])), t));
    end
    // Reset in mid-run, fuse now low
    @(posedge clk_sys_in);
    fuse_cpu_undivided_in <= 1'b0;
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    apb(0, IDX_RELOAD, 0); chk(rdata, 32'h000000FF);
    apb(0, IDX_PCS0, 0); chk(rdata, 32'h00000000);
    // Write without lane zero strobe must leave the register alone
    pstrb_in <= 4'h0;
    apb(1, IDX_RELOAD, 32'h00000012);
    pstrb_in <= 4'hF;
    apb(0, IDX_RELOAD, 0); chk(rdata, 32'h000000FF);
    close_out;
  end
endmodule
